/* File: core/chan_addr.v */
// Effective memory address of one channel's current sample
`include "dma_defs.vh"
module chan_addr (
  // Channel setup
  input wire [15:0] start,
  input wire offsetBit,
  input wire [13:0] len,
  // Progress
  input wire pong,
  input wire [13:0] idx,
  // Result
  output wire memY,
  output wire [14:0] addr
);

  wire [16:0] span;
  wire [16:0] sum;

  // Offset bit moves the twin buffer pair past its first pair
  assign span = {3'h0, len} * (offsetBit ? 17'h00002 : 17'h00000);
  assign sum = {2'h0, start[14:0]} + span +
               (pong ? {3'h0, len} : 17'h00000) + {3'h0, idx};
  assign memY = start[`POS_MEM_SEL];
  assign addr = sum[14:0];

endmodule

/* File: core/dma_defs.vh */
// Constants for the ping/pong DMA engine: register map, fields, resets
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_STATUS1 8'h04
`define IDX_WBUF1 8'h10
`define IDX_WBUF2 8'h12
`define IDX_WBUF3 8'h14
`define IDX_WBUF4 8'h16
`define IDX_RBUF1 8'h20
`define IDX_RBUF2 8'h22
`define IDX_RBUF3 8'h24
`define IDX_CONFIG1 8'h30
`define IDX_OFFSET 8'h32
`define IDX_OUTCTRL 8'h34
`define IDX_TRIGSEL 8'h38

// Field positions
`define POS_FIRST_FULL 31
`define POS_SECOND_FULL 30
`define POS_ACTIVE 16
`define POS_IN_EN 16
`define POS_OUT_OFF 8
`define POS_FMT_SEL 16
`define POS_MEM_SEL 15

// Field widths
`define N_IN 8
`define N_OUT 6
`define W_LEN 14
`define W_SAMPLE 24
`define W_TRIG 5

// Reset values and codes
`define RST_START 16'h0000
`define RST_LEN 14'h0000
`define RST_EN8 8'h00
`define RST_EN6 6'h00
`define RST_TRIG 5'h00
`define TRIG_DMA 5'h00

`endif

/* File: core/dsp_pingpong_dma.v */
// Ping/pong multichannel DMA engine with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port.
`include "dma_defs.vh"
module dsp_pingpong_dma (
  // Clock, reset, clock enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Audio routing side
  input wire sampleTick,
  input wire [191:0] inSamples,
  output reg [143:0] outSamples_r,
  output reg outValid_r,
  // DSP data memory port, read data one cycle after request
  output reg memEn_r,
  output reg memWe_r,
  output reg memSelY_r,
  output reg [14:0] memAddr_r,
  output reg [23:0] memWdata_r,
  input wire [23:0] memRdata,
  // Firmware side
  output reg dmaStart_r,
  output reg fwStart_r,
  output reg dmaEvent_r
);

  localparam S_IDLE = 2'h0;
  localparam S_RUN = 2'h1;
  localparam S_FIN = 2'h2;

  // Register-file state
  reg [15:0] inStart_r [0:7];
  reg [15:0] outStart_r [0:5];
  reg [7:0] inEn_r;
  reg [5:0] outEn_r;
  reg [13:0] len_r;
  reg [7:0] inOff_r;
  reg [5:0] outOff_r;
  reg fmtSel_r;
  reg [4:0] trigSel_r;
  reg firstFull_r;
  reg secondFull_r;
  reg [7:0] active_r;

  // Bus data-phase state
  reg wrPh_r;
  reg [9:0] wrIdx_r;

  // Engine state
  reg [1:0] state_r;
  reg [3:0] step_r;
  reg [13:0] idx_r;
  reg pong_r;
  reg rdVld_r;
  reg [2:0] rdCh_r;
  reg rdTake_r;
  reg [2:0] rdTakeCh_r;
  reg [23:0] inLatch_r [0:7];

  // Combinational helpers
  reg [31:0] rdMux;
  reg [15:0] curStart;
  reg curOff;
  wire curY;
  wire [14:0] curAddr;
  wire [23:0] wrConv;
  wire [23:0] rdConv;
  wire runOk;
  wire busTake;
  wire lastIdx;
  wire [2:0] outCh;
  integer i;

  // Address-phase decode shared by read and write paths
  function isReg;
    input [9:0] a;
    input [7:0] idx;
    begin
      isReg = (a == {2'h0, idx});
    end
  endfunction

  assign busTake = hsel && htrans[1] && hready;
  assign runOk = ((|inEn_r) || (|outEn_r)) && (len_r != `RST_LEN);
  assign lastIdx = (idx_r == len_r - 14'h0001);
  assign outCh = step_r[2:0] - 3'h0;

  // Current channel's start field and offset bit
  always @* begin
    if (step_r < 4'h8) begin
      curStart = inStart_r[step_r[2:0]];
      curOff = inOff_r[step_r[2:0]];
    end else begin
      curStart = outStart_r[step_r[2:0]];
      curOff = outOff_r[step_r[2:0]];
    end
  end

  chan_addr addrGen (
    .start(curStart),
    .offsetBit(curOff),
    .len(len_r),
    .pong(pong_r),
    .idx(idx_r),
    .memY(curY),
    .addr(curAddr)
  );

  sample_fmt wrFmt (
    .din(inLatch_r[step_r[2:0]]),
    .dout(wrConv),
    .toDsp(1'b1),
    .q023Mode(fmtSel_r)
  );

  sample_fmt rdFmt (
    .din(memRdata),
    .dout(rdConv),
    .toDsp(1'b0),
    .q023Mode(fmtSel_r)
  );

  // Read mux; unmapped words read as zero
  always @* begin
    rdMux = 32'h00000000;
    if (isReg(haddr[11:2], `IDX_STATUS1)) begin
      rdMux[`POS_FIRST_FULL] = firstFull_r;
      rdMux[`POS_SECOND_FULL] = secondFull_r;
      rdMux[`POS_ACTIVE +: 8] = active_r;
    end else if (isReg(haddr[11:2], `IDX_WBUF1)) begin
      rdMux = {inStart_r[1], inStart_r[0]};
    end else if (isReg(haddr[11:2], `IDX_WBUF2)) begin
      rdMux = {inStart_r[3], inStart_r[2]};
    end else if (isReg(haddr[11:2], `IDX_WBUF3)) begin
      rdMux = {inStart_r[5], inStart_r[4]};
    end else if (isReg(haddr[11:2], `IDX_WBUF4)) begin
      rdMux = {inStart_r[7], inStart_r[6]};
    end else if (isReg(haddr[11:2], `IDX_RBUF1)) begin
      rdMux = {outStart_r[1], outStart_r[0]};
    end else if (isReg(haddr[11:2], `IDX_RBUF2)) begin
      rdMux = {outStart_r[3], outStart_r[2]};
    end else if (isReg(haddr[11:2], `IDX_RBUF3)) begin
      rdMux = {outStart_r[5], outStart_r[4]};
    end else if (isReg(haddr[11:2], `IDX_CONFIG1)) begin
      rdMux[`POS_IN_EN +: 8] = inEn_r;
      rdMux[`W_LEN-1:0] = len_r;
    end else if (isReg(haddr[11:2], `IDX_OFFSET)) begin
      rdMux[7:0] = inOff_r;
    end else if (isReg(haddr[11:2], `IDX_OUTCTRL)) begin
      rdMux[5:0] = outEn_r;
      rdMux[`POS_OUT_OFF +: 6] = outOff_r;
      rdMux[`POS_FMT_SEL] = fmtSel_r;
    end else if (isReg(haddr[11:2], `IDX_TRIGSEL)) begin
      rdMux[`W_TRIG-1:0] = trigSel_r;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY, word accesses only
  always @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wrPh_r <= 1'b0;
      wrIdx_r <= 10'h000;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wrPh_r <= busTake && hwrite;
        wrIdx_r <= haddr[11:2];
      end
      if (busTake && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // Register writes land in the data phase
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < `N_IN; i = i + 1) begin
        inStart_r[i] <= `RST_START;
      end
      for (i = 0; i < `N_OUT; i = i + 1) begin
        outStart_r[i] <= `RST_START;
      end
      inEn_r <= `RST_EN8;
      outEn_r <= `RST_EN6;
      len_r <= `RST_LEN;
      inOff_r <= `RST_EN8;
      outOff_r <= `RST_EN6;
      fmtSel_r <= 1'b0;
      trigSel_r <= `RST_TRIG;
    end else if (ce && wrPh_r) begin
      // Start and length fields are taken as written at any time;
      // software must keep them still while channels run
      if (isReg(wrIdx_r, `IDX_WBUF1)) begin
        {inStart_r[1], inStart_r[0]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_WBUF2)) begin
        {inStart_r[3], inStart_r[2]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_WBUF3)) begin
        {inStart_r[5], inStart_r[4]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_WBUF4)) begin
        {inStart_r[7], inStart_r[6]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_RBUF1)) begin
        {outStart_r[1], outStart_r[0]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_RBUF2)) begin
        {outStart_r[3], outStart_r[2]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_RBUF3)) begin
        {outStart_r[5], outStart_r[4]} <= hwdata;
      end
      if (isReg(wrIdx_r, `IDX_CONFIG1)) begin
        inEn_r <= hwdata[`POS_IN_EN +: 8];
        len_r <= hwdata[`W_LEN-1:0];
      end
      if (isReg(wrIdx_r, `IDX_OFFSET)) begin
        inOff_r <= hwdata[7:0];
      end
      if (isReg(wrIdx_r, `IDX_OUTCTRL)) begin
        outEn_r <= hwdata[5:0];
        outOff_r <= hwdata[`POS_OUT_OFF +: 6];
        fmtSel_r <= hwdata[`POS_FMT_SEL];
      end
      if (isReg(wrIdx_r, `IDX_TRIGSEL)) begin
        trigSel_r <= hwdata[`W_TRIG-1:0];
      end
    end
  end

  // Snapshot all input samples at the tick so the walk sees one frame
  genvar g;
  generate
    for (g = 0; g < `N_IN; g = g + 1) begin : gLatch
      always @(posedge clk) begin
        if (!rst_n) begin
          inLatch_r[g] <= 24'h000000;
        end else if (ce && state_r == S_IDLE && sampleTick) begin
          inLatch_r[g] <= inSamples[g*24 +: 24];
        end
      end
    end
  endgenerate

  // Frame walk: steps 0-7 write input channels, 8-13 read outputs.
  // One memory access per cycle keeps a single-port memory sufficient.
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      step_r <= 4'h0;
      idx_r <= 14'h0000;
      pong_r <= 1'b0;
      rdVld_r <= 1'b0;
      rdCh_r <= 3'h0;
      rdTake_r <= 1'b0;
      rdTakeCh_r <= 3'h0;
      memEn_r <= 1'b0;
      memWe_r <= 1'b0;
      memSelY_r <= 1'b0;
      memAddr_r <= 15'h0000;
      memWdata_r <= 24'h000000;
      outSamples_r <= 144'h0;
      outValid_r <= 1'b0;
      firstFull_r <= 1'b0;
      secondFull_r <= 1'b0;
      active_r <= `RST_EN8;
      dmaStart_r <= 1'b0;
      fwStart_r <= 1'b0;
      dmaEvent_r <= 1'b0;
    end else if (ce) begin
      memEn_r <= 1'b0;
      memWe_r <= 1'b0;
      rdVld_r <= 1'b0;
      outValid_r <= 1'b0;
      dmaStart_r <= 1'b0;
      fwStart_r <= 1'b0;
      dmaEvent_r <= 1'b0;
      active_r <= runOk ? inEn_r : `RST_EN8;
      // Memory registers the request, so its data is one cycle later
      rdTake_r <= rdVld_r;
      rdTakeCh_r <= rdCh_r;
      if (rdTake_r) begin
        outSamples_r[rdTakeCh_r*24 +: 24] <= rdConv;
      end
      case (state_r)
        S_IDLE: begin
          step_r <= 4'h0;
          if (!runOk) begin
            // All channels off or zero length: next run restarts at ping word 0
            idx_r <= 14'h0000;
            pong_r <= 1'b0;
          end else if (sampleTick) begin
            state_r <= S_RUN;
          end
        end
        S_RUN: begin
          memSelY_r <= curY;
          memAddr_r <= curAddr;
          memWdata_r <= wrConv;
          if (step_r < 4'h8) begin
            memEn_r <= inEn_r[step_r[2:0]];
            memWe_r <= inEn_r[step_r[2:0]];
          end else begin
            // Outputs use the same ping/pong phase as inputs
            memEn_r <= outEn_r[outCh];
            rdVld_r <= outEn_r[outCh];
            rdCh_r <= outCh;
          end
          if (step_r == 4'hD) begin
            state_r <= S_FIN;
          end else begin
            step_r <= step_r + 4'h1;
          end
        end
        S_FIN: begin
          // Wait here until the last read has been captured
          if (!rdVld_r && !rdTake_r) begin
            state_r <= S_IDLE;
            outValid_r <= 1'b1;
            if (lastIdx) begin
              idx_r <= 14'h0000;
              pong_r <= ~pong_r;
              dmaStart_r <= 1'b1;
              fwStart_r <= (trigSel_r == `TRIG_DMA);
              dmaEvent_r <= 1'b1;
              if (!pong_r) begin
                firstFull_r <= 1'b1;
                secondFull_r <= 1'b0;
              end else begin
                secondFull_r <= 1'b1;
                firstFull_r <= 1'b0;
              end
            end else begin
              idx_r <= idx_r + 14'h0001;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: core/sample_fmt.v */
// Sample format converter between routing side (Q0.23) and DSP memory
module sample_fmt (
  // Sample in and out
  input wire [23:0] din,
  output reg [23:0] dout,
  // Direction and mode
  input wire toDsp,
  input wire q023Mode
);

  // Default keeps Q3.20 in memory: full scale sits at 0x100000/0xF00000
  always @* begin
    if (q023Mode) begin
      dout = din;
    end else if (toDsp) begin
      dout = {{3{din[23]}}, din[23:3]};
    end else if (din[23:20] != {4{din[23]}}) begin
      // Saturate: values beyond +-1.0 cannot fit back into Q0.23
      dout = din[23] ? 24'h800000 : 24'h7FFFFF;
    end else begin
      dout = {din[20:0], 3'h0};
    end
  end

endmodule

/* File: verif/dma_pingpong_monitor.sv */
// Port checker for the ping/pong DMA engine
module dma_pingpong_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic memEn_r,
  input wire logic memWe_r,
  input wire logic outValid_r,
  input wire logic dmaStart_r,
  input wire logic fwStart_r,
  input wire logic dmaEvent_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A finished buffer or frame shows for exactly one cycle
  sequence s_one_start;
    dmaStart_r ##1 !dmaStart_r;
  endsequence
  sequence s_one_frame;
    outValid_r ##1 !outValid_r;
  endsequence
  property p_rst;
    $rose(rst_n) |-> !memEn_r && !dmaStart_r && !outValid_r;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_evt; dmaEvent_r |-> dmaStart_r; endproperty
  a_evt: assert property (p_evt) else $error("event alone");
  property p_fw; fwStart_r |-> dmaStart_r; endproperty
  a_fw: assert property (p_fw) else $error("firmware start alone");
  property p_start; dmaStart_r |-> s_one_start; endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_ov; outValid_r |-> s_one_frame; endproperty
  a_ov: assert property (p_ov) else $error("frame valid too long");
  // Output frame is only published once all reads are over
  property p_ovidle; outValid_r |-> !memEn_r; endproperty
  a_ovidle: assert property (p_ovidle) else $error("busy at frame");
  property p_we; memWe_r |-> memEn_r; endproperty
  a_we: assert property (p_we) else $error("write without enable");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus stalled or error");
endmodule

bind dsp_pingpong_dma dma_pingpong_monitor chk (
  .clk, .rst_n, .hreadyout, .hresp, .memEn_r, .memWe_r, .outValid_r,
  .dmaStart_r, .fwStart_r, .dmaEvent_r
);

/* File: verif/dsp_mem_model.sv */
// Behavioural model of the DSP X and Y data memories
module dsp_mem_model (
  // Clock
  input wire logic clk,
  // Request from the engine
  input wire logic memEn_r,
  input wire logic memWe_r,
  input wire logic memSelY_r,
  input wire logic [14:0] memAddr_r,
  input wire logic [23:0] memWdata_r,
  // Read data, valid one cycle after a read
  output logic [23:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] memX [0:32767];
  logic [23:0] memY [0:32767];
  // Each word holds its own address until overwritten
  initial begin
    memRdata = 24'h000000;
    for (int i = 0; i < 32768; i++) begin
      memX[i] = 24'(i);
      memY[i] = 24'(i);
    end
  end
  // Idle cycles toggle the data so a late capture never sees a match
  always @(posedge clk) begin
    if (memEn_r && !memWe_r) begin
      memRdata <= memSelY_r ? memY[memAddr_r] : memX[memAddr_r];
    end else begin
      memRdata <= ~memRdata;
    end
    if (memEn_r && memWe_r && memSelY_r) memY[memAddr_r] <= memWdata_r;
    if (memEn_r && memWe_r && !memSelY_r) memX[memAddr_r] <= memWdata_r;
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the ping/pong DMA engine
`include "dma_defs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sampleTick = 0;
  logic ce = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic [191:0] inSamples = 0;
  logic [143:0] outSamples_r;
  logic hreadyout, hresp, outValid_r, memEn_r, memWe_r, memSelY_r;
  logic [14:0] memAddr_r;
  logic [23:0] memWdata_r, memRdata;
  logic dmaStart_r, fwStart_r, dmaEvent_r;
  logic [15:0] st [0:7];
  logic [15:0] ost [0:5];
  int failures = 0, tests_run = 0, cyc = 0, nStart = 0, nFw = 0, nEvt = 0;
  always #2 clk = ~clk;
  dsp_pingpong_dma uut (.clk, .rst_n, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hresp,
    .hrdata, .sampleTick, .inSamples, .outSamples_r, .outValid_r, .memEn_r,
    .memWe_r, .memSelY_r, .memAddr_r, .memWdata_r, .memRdata, .dmaStart_r,
    .fwStart_r, .dmaEvent_r);
  dsp_mem_model mem (.clk, .memEn_r, .memWe_r, .memSelY_r, .memAddr_r,
    .memWdata_r, .memRdata);
  // Pulse counters and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (dmaStart_r === 1'h1) nStart++;
    if (fwStart_r === 1'h1) nFw++;
    if (dmaEvent_r === 1'h1) nEvt++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d, errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {2'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // Negative samples so the Q3.20 shift must keep the sign
  function automatic logic [23:0] smp(int n, int f);
    return 24'hF00000 ^ 24'(n << 12) ^ 24'(f << 4);
  endfunction
  // One audio frame: word f of the ping/pong cycle, length two
  task automatic frame(input int f, input logic q);
    int k;
    logic [14:0] a;
    logic [23:0] v, e;
    for (k = 0; k < 8; k++) inSamples[24*k +: 24] <= smp(k, f);
    sampleTick <= 1'h1;
    @(posedge clk);
    sampleTick <= 1'h0;
    k = 0;
    do begin @(posedge clk); k++; end while (outValid_r !== 1'h1 && k < 40);
    `CHK(outValid_r, 1'h1)
    for (k = 0; k < 6; k++) begin
      a = ost[k][14:0] + 15'(((f / 2) % 2) * 2 + f % 2);
      // One word holds +1.0, which cannot be shown in Q0.23 and clips in the default Q3.20 mode
      v = (a == 15'h250) ? 24'h100000 : {9'h0, a};
      e = q ? v : (v == 24'h100000) ? 24'h7FFFFF : {v[20:0], 3'h0};
      `CHK(outSamples_r[24*k +: 24], e)
    end
    repeat (4) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      v = smp(k, f);
      e = q ? v : {{3{v[23]}}, v[23:3]};
      a = st[k][14:0] + 15'((k == 7) * 4 + ((f / 2) % 2) * 2 + f % 2);
      v = st[k][15] ? mem.memY[a] : mem.memX[a];
      `CHK(v, e)
    end
  endtask
  initial begin
    int i;
    for (i = 0; i < 8; i++)
      st[i] = (i == 1 ? 16'h8000 : 16'h0000) | 16'(i * 16);
    for (i = 0; i < 6; i++) ost[i] = 16'h8200 + 16'(i * 16);
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    ce <= 1'h1;
    mem.memY[15'h250] = 24'h100000;
    bus(0, `IDX_STATUS1, 0);
    `CHK(rd, 32'h00000000)
    bus(0, `IDX_WBUF4, 0);
    `CHK(rd, 32'h00000000)
    bus(0, 8'h3C, 0);
    `CHK(rd, 32'h00000000)
    // Frozen clock enable: a write issued meanwhile must not land
    ce <= 1'h0;
    bus(1, `IDX_WBUF4, 32'hFFFFFFFF);
    ce <= 1'h1;
    bus(0, `IDX_WBUF4, 0);
    `CHK(rd, 32'h00000000)
    // Addresses are set while every channel is still disabled
    for (i = 0; i < 4; i++)
      bus(1, 8'(`IDX_WBUF1 + 2 * i), {st[2*i+1], st[2*i]});
    for (i = 0; i < 3; i++)
      bus(1, 8'(`IDX_RBUF1 + 2 * i), {ost[2*i+1], ost[2*i]});
    bus(0, `IDX_WBUF1, 0);
    `CHK(rd, {st[1], st[0]})
    bus(1, `IDX_OFFSET, 32'h00000080);
    bus(1, `IDX_TRIGSEL, 32'h00000000);
    bus(1, `IDX_CONFIG1, 32'h00FF0002);
    bus(1, `IDX_OUTCTRL, 32'h0000003F);
    for (i = 0; i < 6; i++) begin
      if (i == 4) begin
        bus(1, `IDX_TRIGSEL, 32'h00000001);
        bus(1, `IDX_OUTCTRL, 32'h0001003F);
      end
      frame(i, i >= 4);
      `CHK(nStart, (i + 1) / 2)
      `CHK(nEvt, (i + 1) / 2)
      `CHK(nFw, (i < 4) ? (i + 1) / 2 : 2)
      bus(0, `IDX_STATUS1, 0);
      `CHK(rd[31:30], 12'h968 >> (2 * i) & 2'h3)
      `CHK(rd[23:16], 8'hFF)
    end
    finish_test();
  end
endmodule
